// ===== include/sram_port_pkg.sv
// shared constants, types and helpers of the flow-through burst sram port
package sram_port_pkg;

    // =========================================================
    // geometry
    localparam int ADDR_W = 18;              // word address width
    localparam int LANES  = 4;               // byte lanes per word
    localparam int LANE_W = 9;               // eight data bits plus parity
    localparam int DATA_W = LANES * LANE_W;  // bus width
    localparam int BUF_DEPTH = 2;            // entries in the write buffer

    // =========================================================
    // reset values and burst counter constants
    localparam logic [1:0]       STEP_FIRST = 2'h0;
    localparam logic [1:0]       STEP_INC   = 2'h1;
    localparam logic             RST_ORDER  = 1'b1;  // interleaved
    localparam logic             RST_SLEEP  = 1'b0;  // awake
    localparam logic             RST_OE_N   = 1'b1;  // outputs off
    localparam logic [LANES-1:0] LANES_OFF  = 4'hf;  // no lane written

    // =========================================================
    // types
    typedef enum logic [1:0] {BS_IDLE, BS_READ, BS_WRITE} burst_state_t;

    // data phase scheduled for the cycle after a sampling edge
    typedef struct packed {
        logic              valid;
        logic              is_read;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane_n;
    } phase_t;

    // one captured write on its way to the array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane_n;
        logic [DATA_W-1:0] data;
    } wr_word_t;

    localparam int WORD_W = $bits(wr_word_t);

    // =========================================================
    // helpers
    // overlay the lanes whose select is low onto an older word
    function automatic logic [DATA_W-1:0] merge_lanes(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [LANES-1:0]  sel_n);
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (!sel_n[i]) begin
                r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        return r;
    endfunction : merge_lanes

    // low two address bits for a burst step
    function automatic logic [1:0] burst_low(
        input logic [1:0] start,
        input logic [1:0] step,
        input logic       interleave);
        return interleave ? (start ^ step) : 2'(start + step);
    endfunction : burst_low

endpackage : sram_port_pkg

// ===== core/pin_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         mclk,  // clock
    input  wire logic         rst,   // synchronous reset
    input  wire logic [W-1:0] pin,   // asynchronous level
    output logic      [W-1:0] level  // filtered level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // =========================================================
    // stage one feeds stage two only, metastability stays contained
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_q  <= RST;
            s2_q  <= RST;
            s3_q  <= RST;
            level <= RST;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level <= s3_q;
            end
        end
    end
endmodule : pin_sync3

// ===== core/word_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module word_buf2 #(
    parameter int W = 8
) (
    input  wire logic         mclk,       // clock
    input  wire logic         rst,        // synchronous reset
    input  wire logic         in_valid,   // word offered
    output logic              in_ready,   // room for a word
    input  wire logic [W-1:0] in_data,    // word in
    output logic              out_valid,  // head word present
    input  wire logic         out_ready,  // drain accepts head
    output logic      [W-1:0] out_data    // head word
);
    logic [W-1:0] ent_q [2];
    logic [1:0]   cnt_q;
    logic         push;
    logic         pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = ent_q[0];

    // =========================================================
    // occupancy
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        end
    end

    // shift on pop, new word lands behind the survivors
    always_ff @(posedge mclk) begin
        if (pop) begin
            ent_q[0] <= ent_q[1];
        end
        if (push) begin
            ent_q[1'(cnt_q - {1'b0, pop})] <= in_data;
        end
    end
endmodule : word_buf2

// ===== core/flowthrough_burst_sram_port.sv
// flow-through burst sram port: pipelined control, two-bit burst counter, data bus
`timescale 1ns/1ps
// Functional notes
// - inactive select on load starts deselect cycle
// - bus floats one cycle after deselect
// - pending transfer completes during deselect cycle
// - load during burst ends that burst
// - direction fixed at load, ignored on advance
// - direction low with load and select writes
// - lanes with control, data one cycle later
// - hold high makes edge invisible
// - held edge keeps control and read data registers unchanged
// - burst advances only low two address bits
// - bus floats from reset until read scheduled
// - read data driven next cycle, then floats
// - write data captured next cycle regardless selects
// - order defaults interleaved, sleep defaults off
// - selected only when all three selects true
// - interleaved order is start xor step
// - linear order is start plus step
// - each low lane select writes one lane
module flowthrough_burst_sram_port (
    input  wire logic                             mclk,            // clock
    input  wire logic                             rst,             // sync reset
    input  wire logic [sram_port_pkg::ADDR_W-1:0] addr,            // word address
    input  wire logic                             read_not_write,  // high read
    input  wire logic                             advance_or_load, // low load
    input  wire logic                             chip_sel_a_n,    // select, low
    input  wire logic                             chip_sel_c_n,    // select, low
    input  wire logic                             chip_sel_b,      // select, high
    input  wire logic                             clock_hold_n,    // high holds
    input  wire logic [sram_port_pkg::LANES-1:0]  lane_write_n,    // lane selects
    input  wire logic                             burst_order_sel, // 1 interleave
    input  wire logic                             sleep_request,   // async sleep
    input  wire logic                             out_en_n,        // async enable
    input  wire logic [sram_port_pkg::DATA_W-1:0] dq_in,           // bus level in
    output logic      [sram_port_pkg::DATA_W-1:0] dq_out,          // read data
    output logic                                  dq_oe            // bus drive
);
    import sram_port_pkg::*;

    // =========================================================
    // signals
    logic [DATA_W-1:0] mem [2**ADDR_W];
    burst_state_t      bstate_q;
    burst_state_t      bstate_d;
    phase_t            phase_q;
    phase_t            phase_d;
    phase_t            phase_n;
    logic [ADDR_W-3:0] base_q;
    logic [ADDR_W-3:0] base_d;
    logic [1:0]        start_q;
    logic [1:0]        start_d;
    logic [1:0]        step_q;
    logic [1:0]        step_d;
    logic              order_s;
    logic              sleep_s;
    logic              oe_n_s;
    logic              held;
    logic              load;
    logic              selected;
    logic              start_ok;
    logic              wr_room;
    wr_word_t          cap_word;
    logic              cap_valid;
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic              buf_out_ready;
    wr_word_t          head;
    logic [DATA_W-1:0] rd_word;

    // =========================================================
    // static and asynchronous pins; reset values stand for undriven pins
    pin_sync3 #(.W(1), .RST(RST_ORDER)) u_order_sync (
        .mclk  (mclk),
        .rst   (rst),
        .pin   (burst_order_sel),
        .level (order_s)
    );

    pin_sync3 #(.W(1), .RST(RST_SLEEP)) u_sleep_sync (
        .mclk  (mclk),
        .rst   (rst),
        .pin   (sleep_request),
        .level (sleep_s)
    );

    // enable is sampled, so it acts four to five cycles late, not at once
    pin_sync3 #(.W(1), .RST(RST_OE_N)) u_oe_sync (
        .mclk  (mclk),
        .rst   (rst),
        .pin   (out_en_n),
        .level (oe_n_s)
    );

    // =========================================================
    // control decode
    assign held     = clock_hold_n;
    assign load     = !advance_or_load;
    assign selected = !chip_sel_a_n && !chip_sel_c_n && chip_sel_b;
    // a write must find the buffer able to take it in the data phase
    assign wr_room  = buf_in_ready && (!buf_out_valid || buf_out_ready);
    assign start_ok = load && selected && !sleep_s
                      && (read_not_write || wr_room);

    // =========================================================
    // next burst and data phase
    always_comb begin
        bstate_d = bstate_q;
        base_d   = base_q;
        start_d  = start_q;
        step_d   = step_q;
        phase_d  = '0;
        if (load) begin
            // any load, taken or not, ends the burst in progress
            bstate_d = BS_IDLE;
            step_d   = STEP_FIRST;
            if (start_ok) begin
                bstate_d       = read_not_write ? BS_READ : BS_WRITE;
                base_d         = addr[ADDR_W-1:2];
                start_d        = addr[1:0];
                phase_d.valid  = 1'b1;
                phase_d.is_read = read_not_write;
                phase_d.addr   = addr;
                phase_d.lane_n = lane_write_n;
            end
        end else if (bstate_q == BS_WRITE && !wr_room) begin
            // buffer cannot take another word: the burst write stops here
            bstate_d = BS_IDLE;
        end else if (bstate_q != BS_IDLE) begin
            step_d          = 2'(step_q + STEP_INC);
            phase_d.valid   = 1'b1;
            phase_d.is_read = (bstate_q == BS_READ);
            phase_d.addr    = {base_q, burst_low(start_q, step_d, order_s)};
            phase_d.lane_n  = lane_write_n;
        end
    end

    // phase that will be current after this edge
    assign phase_n = held ? phase_q : phase_d;

    // =========================================================
    // control registers, frozen while the edge is held
    always_ff @(posedge mclk) begin
        if (rst) begin
            bstate_q <= BS_IDLE;
            phase_q  <= '0;
            base_q   <= '0;
            start_q  <= STEP_FIRST;
            step_q   <= STEP_FIRST;
        end else if (!held) begin
            bstate_q <= bstate_d;
            phase_q  <= phase_d;
            base_q   <= base_d;
            start_q  <= start_d;
            step_q   <= step_d;
        end
    end

    // =========================================================
    // write capture: data of a write phase is on the bus this cycle,
    // whatever the selects say now
    assign cap_valid     = !held && phase_q.valid && !phase_q.is_read;
    assign cap_word.addr   = phase_q.addr;
    assign cap_word.lane_n = phase_q.lane_n;
    assign cap_word.data   = dq_in;
    // array writes pause while asleep; the buffer then holds the words
    assign buf_out_ready = !sleep_s;

    word_buf2 #(.W(WORD_W)) u_wr_buf (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (cap_valid),
        .in_ready  (buf_in_ready),
        .in_data   (cap_word),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (head)
    );

    // array update, lane by lane
    always_ff @(posedge mclk) begin
        if (buf_out_valid && buf_out_ready) begin
            mem[head.addr] <= merge_lanes(mem[head.addr], head.data, head.lane_n);
        end
    end

    // =========================================================
    // read path: forward the buffer head and the word just captured,
    // so a read right after a write sees the new data
    always_comb begin
        rd_word = mem[phase_d.addr];
        if (buf_out_valid && head.addr == phase_d.addr) begin
            rd_word = merge_lanes(rd_word, head.data, head.lane_n);
        end
        if (cap_valid && cap_word.addr == phase_d.addr) begin
            rd_word = merge_lanes(rd_word, cap_word.data, cap_word.lane_n);
        end
    end

    // data register updates only at a taken edge, so held data stays put
    always_ff @(posedge mclk) begin
        if (rst) begin
            dq_out <= '0;
        end else if (!held && phase_d.valid && phase_d.is_read) begin
            dq_out <= rd_word;
        end
    end

    // drive only during a current read phase with enable low
    always_ff @(posedge mclk) begin
        if (rst) begin
            dq_oe <= 1'b0;
        end else begin
            dq_oe <= phase_n.valid && phase_n.is_read && !oe_n_s;
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // checks watch only what this block drives; pin setup is the controller's
    // business. sleep refuses loads and stalls the drain, so antecedents
    // that expect a write burst to go on ask for buffer room first.
    // held edges stay out of most antecedents: no control register moves on them.

    chk_desel_no_op: assert property (
        (!held && load && !selected) |=> (!phase_q.valid && bstate_q == BS_IDLE))
        else $error("deselect load still scheduled an access");

    chk_bus_release: assert property (
        (!held && load && !selected) |=> !dq_oe)
        else $error("bus still driven after deselect cycle");

    chk_read_drive: assert property (
        (!held && start_ok && read_not_write && !oe_n_s) |=> dq_oe)
        else $error("loaded read not driven in next cycle");

    chk_write_capture: assert property (
        (!held && start_ok && !read_not_write) ##1 (!held)
            |=> (buf_out_valid && (head.addr == $past(phase_q.addr)
                 || $past(buf_out_valid) && !$past(sleep_s))))
        else $error("write data phase did not capture");

    chk_burst_end: assert property (
        (!held && load) |=> (step_q == STEP_FIRST))
        else $error("load did not restart burst counter");

    chk_dir_fixed: assert property (
        (!held && !load && bstate_q != BS_IDLE && $past(!held))
            |=> (bstate_q == $past(bstate_q) || bstate_q == BS_IDLE))
        else $error("burst direction changed without load");

    chk_hold_keeps: assert property (
        held |=> ($stable(phase_q) && $stable(step_q) && $stable(dq_out)))
        else $error("held edge changed internal state");

    chk_interleave: assert property (
        (!held && !load && bstate_q == BS_READ && order_s)
            |=> (phase_q.addr[1:0] == (start_q ^ step_q)))
        else $error("interleaved burst address wrong");

    chk_linear: assert property (
        (!held && !load && bstate_q == BS_READ && !order_s)
            |=> (phase_q.addr[1:0] == 2'(start_q + step_q)))
        else $error("linear burst address wrong");

    chk_base_fixed: assert property (
        (!held && !load && bstate_q != BS_IDLE && phase_q.valid
            && (bstate_q == BS_READ || wr_room))
            |=> (phase_q.addr[ADDR_W-1:2] == $past(phase_q.addr[ADDR_W-1:2])))
        else $error("burst moved upper address bits");

    chk_oe_gate: assert property (
        dq_oe |-> (phase_q.valid && phase_q.is_read && !$past(oe_n_s)))
        else $error("bus driven outside a read phase");

    // enable and reset keep the bus released
    chk_oe_off: assert property (
        oe_n_s |=> !dq_oe)
        else $error("bus driven with enable high");

    chk_reset_float: assert property (
        $past(rst) |-> !dq_oe)
        else $error("bus driven right after reset");

    chk_write_float: assert property (
        (!held && start_ok && !read_not_write) |=> !dq_oe)
        else $error("bus driven in a write data phase");

    // a taken load carries address, direction and lanes into its phase
    chk_load_take: assert property (
        (!held && start_ok) |=> (phase_q.addr == $past(addr)
            && phase_q.is_read == $past(read_not_write)))
        else $error("load lost address or direction");

    chk_lane_take: assert property (
        (!held && start_ok) |=> (phase_q.lane_n == $past(lane_write_n)))
        else $error("lane selects not taken with control");

    chk_sel_refuse: assert property (
        (!held && load && (chip_sel_a_n || chip_sel_c_n || !chip_sel_b))
            |=> !phase_q.valid)
        else $error("false select started an access");

    chk_desel_end: assert property (
        (!held && load && !start_ok) |=> (bstate_q == BS_IDLE))
        else $error("refused load left burst running");

    // advancing: no phase out of idle, reads stay reads, counter steps by one
    chk_idle_quiet: assert property (
        (!held && !load && bstate_q == BS_IDLE) |=> !phase_q.valid)
        else $error("advance out of idle made a phase");

    chk_adv_dir: assert property (
        (!held && !load && bstate_q == BS_READ) |=> (phase_q.valid && phase_q.is_read))
        else $error("read burst changed direction");

    chk_step_inc: assert property (
        (!held && !load && bstate_q == BS_READ) |=> (step_q == 2'($past(step_q) + STEP_INC)))
        else $error("burst counter did not step by one");

    chk_hold_burst: assert property (
        held |=> ($stable(bstate_q) && $stable(base_q) && $stable(start_q)))
        else $error("held edge moved burst state");

    cov_burst_read: cover property (
        (!held && start_ok && read_not_write) ##1 (!held && !load)[*3]);
    cov_read_desel: cover property (
        (!held && start_ok && read_not_write) ##1 (!held && load && !selected));
    cov_write_read: cover property (
        (!held && start_ok && !read_not_write) ##1 (!held && start_ok && read_not_write));
    cov_hold_read: cover property (dq_oe && held);
    cov_burst_write: cover property (
        (!held && start_ok && !read_not_write) ##1 (!held && !load)[*3]);

endmodule : flowthrough_burst_sram_port

// ===== test/mem_ctrl_model.sv
// controller-side model: drives control, lane selects and write data of the port
`timescale 1ns/1ps
module mem_ctrl_model (
    input  wire logic                             mclk,            // clock
    input  wire logic [sram_port_pkg::DATA_W-1:0] dq_out,          // device read data
    input  wire logic                             dq_oe,           // device drives bus
    output logic      [sram_port_pkg::ADDR_W-1:0] addr,            // word address
    output logic                                  read_not_write,  // high read
    output logic                                  advance_or_load, // low load
    output logic                                  chip_sel_a_n,    // select, low
    output logic                                  chip_sel_c_n,    // select, low
    output logic                                  chip_sel_b,      // select, high
    output logic                                  clock_hold_n,    // high holds
    output logic      [sram_port_pkg::LANES-1:0]  lane_write_n,    // lane selects
    output logic      [sram_port_pkg::DATA_W-1:0] dq_in            // resolved bus
);
    import sram_port_pkg::*;
    logic              drv_q  = 1'b0;  // controller drives write data
    logic [DATA_W-1:0] wd_q   = '0;    // write data on the bus
    logic [DATA_W-1:0] last_q = '0;    // last bus level

    // =========================================================
    // bus resolution: a floating bus shows the inverse of its last level,
    // so a stale word can never pass for a fresh read
    assign dq_in = dq_oe ? dq_out : (drv_q ? wd_q : ~last_q);
    always @(posedge mclk) begin
        last_q <= dq_in;
    end

    // idle controller at time zero: no load, nothing selected
    initial begin
        addr            = '0;
        read_not_write  = 1'b1;
        advance_or_load = 1'b1;
        {chip_sel_a_n, chip_sel_c_n, chip_sel_b} = 3'h6;
        clock_hold_n    = 1'b0;
        lane_write_n    = 4'hf;
    end

    // =========================================================
    // one bus cycle: change after the falling edge, hold through the rising edge
    task automatic step(input logic ld, input logic rnw, input logic [ADDR_W-1:0] a,
                        input logic [LANES-1:0] ln, input logic [2:0] sel,
                        input logic hold, input logic drv, input logic [DATA_W-1:0] wd);
        @(negedge mclk);
        advance_or_load = ~ld;
        read_not_write  = rnw;
        addr            = a;
        {chip_sel_a_n, chip_sel_c_n, chip_sel_b} = sel;
        clock_hold_n    = hold;
        lane_write_n    = ln;
        drv_q           = drv;
        wd_q            = wd;
        @(posedge mclk);
        #1;
    endtask : step
endmodule : mem_ctrl_model

// ===== test/tb.sv
// self-checking bench of the flow-through burst sram port
`timescale 1ns/1ps
module tb;
    import sram_port_pkg::*;
    localparam logic [2:0]        ON = 3'h1;       // all three selects true
    localparam logic [ADDR_W-1:0] A0 = 18'h00010;  // single-word target
    localparam logic [ADDR_W-1:0] B  = 18'h00105;  // burst base, low bits 01
    logic mclk = 1'b0;
    logic rst  = 1'b1;
    logic burst_order_sel, sleep_request, out_en_n, dq_oe;
    logic read_not_write, advance_or_load, chip_sel_a_n, chip_sel_c_n, chip_sel_b;
    logic clock_hold_n;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_write_n, ln;
    logic [DATA_W-1:0] dq_in, dq_out, d;
    logic [2:0]        s;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    int bad_count = 0;
    int checks_done = 0;

    always #20 mclk = ~mclk;

    flowthrough_burst_sram_port dut (.mclk(mclk), .rst(rst), .addr(addr),
        .read_not_write(read_not_write), .advance_or_load(advance_or_load),
        .chip_sel_a_n(chip_sel_a_n), .chip_sel_c_n(chip_sel_c_n), .chip_sel_b(chip_sel_b),
        .clock_hold_n(clock_hold_n), .lane_write_n(lane_write_n),
        .burst_order_sel(burst_order_sel), .sleep_request(sleep_request),
        .out_en_n(out_en_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

    mem_ctrl_model ctl (.mclk(mclk), .dq_out(dq_out), .dq_oe(dq_oe), .addr(addr),
        .read_not_write(read_not_write), .advance_or_load(advance_or_load),
        .chip_sel_a_n(chip_sel_a_n), .chip_sel_c_n(chip_sel_c_n), .chip_sel_b(chip_sel_b),
        .clock_hold_n(clock_hold_n), .lane_write_n(lane_write_n), .dq_in(dq_in));

    // =========================================================
    // comparison, expectation and reference-memory helpers
    task automatic compare(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : compare

    task automatic expect_rd(input logic [ADDR_W-1:0] a);
        compare(DATA_W'(dq_oe), DATA_W'(1'b1));
        compare(dq_out, mem[a]);
    endtask : expect_rd

    task automatic expect_idle;
        compare(DATA_W'(dq_oe), '0);
    endtask : expect_idle

    // only lanes whose select is low take the new bytes
    task automatic mwr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] l,
                       input logic [DATA_W-1:0] v);
        logic [DATA_W-1:0] w;
        w = mem.exists(a) ? mem[a] : '0;
        for (int i = 0; i < LANES; i++) begin
            if (!l[i]) begin
                w[i*LANE_W +: LANE_W] = v[i*LANE_W +: LANE_W];
            end
        end
        mem[a] = w;
    endtask : mwr

    // address of burst step i, interleaved or linear
    function automatic logic [ADDR_W-1:0] brst(input logic [ADDR_W-1:0] b, input int i,
                                               input logic il);
        logic [1:0] k;
        k = 2'(i);
        return {b[ADDR_W-1:2], il ? (b[1:0] ^ k) : 2'(b[1:0] + k)};
    endfunction : brst

    task automatic tally_and_finish;
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // watchdog: a hung sequence counts as a mismatch
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        tally_and_finish;
    end

    // =========================================================
    // main sequence
    initial begin
        burst_order_sel = 1'b1;
        sleep_request   = 1'b0;
        out_en_n        = 1'b0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        // enable restarts its synchroniser at reset: let it settle before reads
        repeat (4) @(negedge mclk);
        // single write whose data phase lands in a deselect cycle
        ctl.step(1, 0, A0, 4'h0, ON, 0, 0, '0); expect_idle;
        ctl.step(1, 0, A0, 4'hf, 3'h5, 0, 1, 36'h9_1234_5678);
        mwr(A0, 4'h0, 36'h9_1234_5678);
        ctl.step(1, 1, A0, 4'hf, ON, 0, 0, '0); expect_rd(A0);
        ctl.step(1, 1, A0, 4'hf, 3'h3, 0, 0, '0); expect_idle;
        // each lane alone, then none, read back to back with the capture
        for (int i = 0; i < 5; i++) begin
            ln = (i < 4) ? ~(4'h1 << i) : 4'hf;
            d  = 36'h3_c3c3_c3c3 + 36'(i * 36'h1_0101_0101);
            ctl.step(1, 0, A0, ln, ON, 0, 0, '0);
            ctl.step(1, 1, A0, 4'hf, ON, 0, 1, d);
            mwr(A0, ln, d);
            expect_rd(A0);
        end
        ctl.step(1, 1, A0, 4'hf, 3'h0, 0, 0, '0); expect_idle;
        // one false select at a time refuses both directions
        for (int i = 0; i < 3; i++) begin
            s = ON ^ (3'h4 >> i);
            ctl.step(1, 0, A0, 4'h0, s, 0, 0, '0);
            ctl.step(1, 1, A0, 4'hf, s, 0, 1, ~mem[A0]); expect_idle;
            ctl.step(1, 1, A0, 4'hf, ON, 0, 0, '0); expect_rd(A0);
            ctl.step(1, 1, A0, 4'hf, s, 0, 0, '0);
        end
        // interleaved burst write; direction and address ignored while advancing
        ctl.step(1, 0, B, 4'h0, ON, 0, 0, '0);
        for (int i = 0; i < 3; i++) begin
            d = 36'h7_1000_0000 + 36'(i);
            ctl.step(0, 1, 18'h3ffff, 4'h0, ON, 0, 1, d);
            mwr(brst(B, i, 1), 4'h0, d);
        end
        ctl.step(1, 1, B, 4'hf, ON, 0, 1, 36'h7_1000_0003);
        mwr(brst(B, 3, 1), 4'h0, 36'h7_1000_0003);
        expect_rd(B);
        for (int i = 1; i < 6; i++) begin
            ctl.step(0, 0, 18'h0, 4'h0, ON, 0, 0, '0); expect_rd(brst(B, i, 1));
        end
        // held edges ignore a deselecting write load and keep the word driven
        repeat (2) begin
            ctl.step(1, 0, A0, 4'h0, 3'h0, 1, 0, '0); expect_rd(brst(B, 5, 1));
        end
        ctl.step(0, 1, 18'h0, 4'hf, ON, 0, 0, '0); expect_rd(brst(B, 6, 1));
        ctl.step(1, 1, 18'h0, 4'hf, 3'h0, 0, 0, '0); expect_idle;
        // linear order once the static pin has passed its synchroniser
        @(negedge mclk);
        burst_order_sel = 1'b0;
        repeat (5) ctl.step(1, 1, 18'h0, 4'hf, 3'h0, 0, 0, '0);
        ctl.step(1, 1, B, 4'hf, ON, 0, 0, '0); expect_rd(B);
        for (int i = 1; i < 5; i++) begin
            ctl.step(0, 1, 18'h0, 4'hf, ON, 0, 0, '0); expect_rd(brst(B, i, 0));
        end
        ctl.step(1, 1, 18'h0, 4'hf, 3'h0, 0, 0, '0); expect_idle;
        // enable high: a read still loads but the bus stays released
        @(negedge mclk);
        out_en_n = 1'b1;
        repeat (4) ctl.step(1, 1, 18'h0, 4'hf, 3'h0, 0, 0, '0);
        ctl.step(1, 1, B, 4'hf, ON, 0, 0, '0); expect_idle;
        tally_and_finish;
    end
endmodule : tb
